// ### dv/pcs_host_model.sv
// Host-side partner: issues configuration cycles and bus event pulses.
// Assumes the bench calls its tasks and that clk_sys is shared with the design.
`timescale 1ns/100ps

module pcs_host_model
(
    input wire logic clk_sys,
    input wire logic [31:0] cfgRdData_r,
    input wire logic cfgRdValid_r,
    output pcs_pkg::pcs_cfg_req_t cfgReq,
    output pcs_pkg::pcs_evt_t busEvt
);
    import pcs_pkg::*;

    initial
    begin
        cfgReq = '0;
        busEvt = '0;
    end

    // One access; idle fields flip so stale values never look like a request
    task automatic cfgAccess(input logic wr, input logic [7:0] addr, input logic [3:0] be,
        input logic [31:0] data, output logic [31:0] rdData, output logic rdValid);
        @(posedge clk_sys);
        #2;
        cfgReq = '{sel: 1'b1, wr: wr, addr: addr, byteEn: be, wrData: data};
        @(posedge clk_sys);
        #2;
        rdData = cfgRdData_r;
        rdValid = cfgRdValid_r;
        cfgReq = '{sel: 1'b0, wr: ~wr, addr: ~addr, byteEn: ~be, wrData: ~data};
    endtask : cfgAccess

    // Events last exactly one clock
    task automatic pulseEvt(input pcs_evt_t e);
        @(posedge clk_sys);
        #2;
        busEvt = e;
        @(posedge clk_sys);
        #2;
        busEvt = '0;
    endtask : pulseEvt

endmodule : pcs_host_model

// ### dv/testbench.sv
// Self-checking bench for the command/status configuration bank.
// Assumes the rtl package and modules are compiled first.
`timescale 1ns/100ps

module testbench;
    import pcs_pkg::*;

    localparam logic [5:0] REV_ID = 6'h2a; // Arbitrary revision value

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    pcs_cfg_req_t cfgReq;
    pcs_evt_t busEvt;
    pcs_dec_t decode = '0;
    logic otherIoEn = 1'b0;
    logic [31:0] cfgRdData_r;
    logic cfgRdValid_r, ioEn_r, memEn_r, bmEn_r, parityEn_r, serrEn_r;
    logic memClaim_r, ioClaim_r, mstReqOut_r, perrOe_r, perrOut_r, serrOe_r, serrOut_r;
    int mIo, mMem, mBm, mPar, mSerr;
    int fMdpe, fSta, fRta, fRma, fSse, fDpe;
    int n_errors = 0;
    int checks_done = 0;
    logic [31:0] lfsrR = 32'h0000_003b;
    logic [31:0] wd;
    pcs_evt_t ev;

    always #25 clk_sys = ~clk_sys;

    pcs_cfg_cmd_status #(.REV_ID(REV_ID)) pcs_cfg_cmd_status_inst
    (
        .clk_sys(clk_sys), .rstn(rstn), .cfgReq(cfgReq), .busEvt(busEvt), .decode(decode),
        .otherIoEn(otherIoEn), .cfgRdData_r(cfgRdData_r), .cfgRdValid_r(cfgRdValid_r),
        .ioEn_r(ioEn_r), .memEn_r(memEn_r), .bmEn_r(bmEn_r), .parityEn_r(parityEn_r),
        .serrEn_r(serrEn_r), .memClaim_r(memClaim_r), .ioClaim_r(ioClaim_r),
        .mstReqOut_r(mstReqOut_r), .perrOe_r(perrOe_r), .perrOut_r(perrOut_r),
        .serrOe_r(serrOe_r), .serrOut_r(serrOut_r)
    );

    pcs_host_model pcs_host_model_inst
    (
        .clk_sys(clk_sys), .cfgRdData_r(cfgRdData_r), .cfgRdValid_r(cfgRdValid_r),
        .cfgReq(cfgReq), .busEvt(busEvt)
    );

    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction : lfsrNext

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // Expected command/status word from the bench model
    function automatic logic [31:0] expCmdStat();
        logic [31:0] w;
        w = 32'h0210_0000;
        w[0] = mIo[0];
        w[1] = mMem[0];
        w[2] = mBm[0];
        w[6] = mPar[0];
        w[8] = mSerr[0];
        w[24] = fMdpe[0];
        w[27] = fSta[0];
        w[28] = fRta[0];
        w[29] = fRma[0];
        w[30] = fSse[0];
        w[31] = fDpe[0];
        return w;
    endfunction : expCmdStat

    task automatic cfgWr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] rd;
        logic rv;
        pcs_host_model_inst.cfgAccess(1'b1, addr, be, d, rd, rv);
        if (addr == 8'h04)
        begin
            if (be[0])
            begin
                mIo = d[0];
                mMem = d[1];
                mBm = d[2];
                mPar = d[6];
            end
            if (be[1])
                mSerr = d[8];
            if (be[3])
            begin
                fMdpe = fMdpe & ~d[24];
                fSta = fSta & ~d[27];
                fRta = fRta & ~d[28];
                fRma = fRma & ~d[29];
                fSse = fSse & ~d[30];
                fDpe = fDpe & ~d[31];
            end
        end
    endtask : cfgWr

    task automatic rdCheck(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic rv;
        pcs_host_model_inst.cfgAccess(1'b0, addr, 4'hf, 32'h0, rd, rv);
        check(rv, 1'b1, "read valid");
        check(rd, exp, "read data");
    endtask : rdCheck

    task automatic checkEnables;
        check({ioEn_r, memEn_r, bmEn_r, parityEn_r, serrEn_r},
            {mIo[0], mMem[0], mBm[0], mPar[0], mSerr[0]}, "enables");
    endtask : checkEnables

    // Sticky flag model; applied after any clear of the same cycle, so set wins
    task automatic modelEvt(input pcs_evt_t e);
        fMdpe = fMdpe | (e.dataParityErr & e.actingMaster & mPar[0]);
        fSta = fSta | e.targetAbortSent;
        fRta = fRta | e.targetAbortRcvd;
        fRma = fRma | e.masterAbortRcvd;
        fSse = fSse | (e.addrParityErr & mSerr[0] & mPar[0]);
        fDpe = fDpe | e.addrParityErr | e.dataParityErr;
    endtask : modelEvt

    task automatic applyReset;
        rstn = 1'b0;
        {mIo, mMem, mBm, mPar, mSerr} = '0;
        {fMdpe, fSta, fRta, fRma, fSse, fDpe} = '0;
        repeat (5) @(posedge clk_sys);
        #2;
        rstn = 1'b1;
    endtask : applyReset

    initial
    begin
        #1000000;
        n_errors++;
        $display("BAD t=%0t run did not finish in time", $time);
        give_verdict();
    end

    initial
    begin
        applyReset();
        checkEnables();
        rdCheck(8'h04, expCmdStat());
        rdCheck(8'h08, {24'h060700, 2'b11, REV_ID});
        $display("test reset_values done");
        cfgWr(8'h08, 4'hf, 32'hffff_ffff);
        rdCheck(8'h08, {24'h060700, 2'b11, REV_ID});
        cfgWr(8'h0c, 4'hf, 32'hffff_ffff);
        rdCheck(8'h0c, 32'h0);
        cfgWr(8'h04, 4'hf, 32'h00ff_ffff);
        checkEnables();
        rdCheck(8'h04, expCmdStat());
        $display("test fixed_fields done");
        for (int i = 0; i < 300; i++)
        begin
            lfsrR = lfsrNext(lfsrR);
            wd = lfsrR;
            lfsrR = lfsrNext(lfsrR);
            cfgWr(8'h04, lfsrR[3:0], wd);
            checkEnables();
            lfsrR = lfsrNext(lfsrR);
            decode = pcs_dec_t'(lfsrR[3:0]);
            otherIoEn = lfsrR[4];
            ev = pcs_evt_t'(lfsrR[10:5]);
            pcs_host_model_inst.pulseEvt(ev);
            check(serrOe_r, ev.addrParityErr & mSerr[0] & mPar[0], "serr pin");
            check(perrOe_r, ev.dataParityErr & mPar[0], "perr pin");
            check({serrOut_r, perrOut_r}, 2'b00, "pin levels");
            check(memClaim_r, (decode.memHit & mMem[0]) | decode.cardMemHit, "mem");
            check(ioClaim_r, decode.ioHit & (mIo[0] | otherIoEn), "io claim");
            check(mstReqOut_r, decode.masterReq & mBm[0], "master req");
            modelEvt(ev);
            rdCheck(8'h04, expCmdStat());
        end
        $display("test random_traffic done");
        // Every event in the same cycle as a clear of every flag
        ev = pcs_evt_t'(6'h3f);
        fork
            cfgWr(8'h04, 4'h8, 32'hff00_0000);
            pcs_host_model_inst.pulseEvt(ev);
        join
        modelEvt(ev);
        check(serrOe_r, mSerr[0] & mPar[0], "serr pin");
        rdCheck(8'h04, expCmdStat());
        $display("test set_beats_clear done");
        applyReset();
        checkEnables();
        rdCheck(8'h04, expCmdStat());
        $display("test mid_reset done");
        give_verdict();
    end

endmodule : testbench

// ### rtl/pcs_cfg_cmd_status.sv
// Command/status and revision/class configuration words for one socket.
// Assumes configuration requests and bus events arrive on the PCI clock,
// which is clk_sys, and that PCI reset drives rstn.
`timescale 1ns/100ps
`include "pcs_params.svh"

module pcs_cfg_cmd_status
#(
    parameter logic [5:0] REV_ID = `PCS_REV_ID_DEFAULT
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire pcs_pkg::pcs_cfg_req_t cfgReq,
    input wire pcs_pkg::pcs_evt_t busEvt,
    input wire pcs_pkg::pcs_dec_t decode,
    input wire logic otherIoEn,
    output logic [31:0] cfgRdData_r,
    output logic cfgRdValid_r,
    output logic ioEn_r,
    output logic memEn_r,
    output logic bmEn_r,
    output logic parityEn_r,
    output logic serrEn_r,
    output logic memClaim_r,
    output logic ioClaim_r,
    output logic mstReqOut_r,
    output logic perrOe_r,
    output logic perrOut_r,
    output logic serrOe_r,
    output logic serrOut_r
);
    import pcs_pkg::*;

    logic cmdWr;
    logic revWr;
    logic cmdRd;
    logic revRd;
    logic lane0Wr;
    logic lane1Wr;
    logic lane3Wr;
    logic serrFire;
    logic perrFire;
    logic [`PCS_FLG_N-1:0] stSet;
    logic [`PCS_FLG_N-1:0] stClr;
    logic [`PCS_FLG_N-1:0] stFlag;
    logic [`PCS_FLG_N-1:0] stWrBits;
    logic [31:0] cmdStatWord;
    logic [31:0] revClassWord;
    logic [31:0] cfgRdData_nxt;

    // Access decode
    always_comb
    begin
        cmdWr = cfgReq.sel & cfgReq.wr & (cfgReq.addr == `PCS_OFF_CMDSTAT);
        revWr = cfgReq.sel & cfgReq.wr & (cfgReq.addr == `PCS_OFF_REVCLASS);
        cmdRd = cfgReq.sel & ~cfgReq.wr & (cfgReq.addr == `PCS_OFF_CMDSTAT);
        revRd = cfgReq.sel & ~cfgReq.wr & (cfgReq.addr == `PCS_OFF_REVCLASS);
        lane0Wr = cmdWr & cfgReq.byteEn[`PCS_LANE_CMDLO];
        lane1Wr = cmdWr & cfgReq.byteEn[`PCS_LANE_CMDHI];
        lane3Wr = cmdWr & cfgReq.byteEn[`PCS_LANE_STHI];
    end

    // Writable command bits
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ioEn_r <= `PCS_EN_RST;
            memEn_r <= `PCS_EN_RST;
            bmEn_r <= `PCS_EN_RST;
            parityEn_r <= `PCS_EN_RST;
        end
        else if (lane0Wr)
        begin
            ioEn_r <= cfgReq.wrData[`PCS_BIT_IOEN];
            memEn_r <= cfgReq.wrData[`PCS_BIT_MEMEN];
            bmEn_r <= cfgReq.wrData[`PCS_BIT_BMEN];
            parityEn_r <= cfgReq.wrData[`PCS_BIT_PERREN];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            serrEn_r <= `PCS_EN_RST;
        end
        else if (lane1Wr)
        begin
            serrEn_r <= cfgReq.wrData[`PCS_BIT_SERREN];
        end
    end

    // Error signalling conditions
    always_comb
    begin
        serrFire = busEvt.addrParityErr & serrEn_r & parityEn_r; // see (R8) see (R9)
        perrFire = busEvt.dataParityErr & parityEn_r; // see (R6)
    end

    // Sticky flag sources
    always_comb
    begin
        stSet = '0;
        stSet[`PCS_FLG_MDPE] = perrFire & busEvt.actingMaster; // see (R12)
        stSet[`PCS_FLG_STA] = busEvt.targetAbortSent; // see (R14)
        stSet[`PCS_FLG_RTA] = busEvt.targetAbortRcvd; // see (R15)
        stSet[`PCS_FLG_RMA] = busEvt.masterAbortRcvd; // see (R16)
        stSet[`PCS_FLG_SSE] = serrFire; // see (R9)
        stSet[`PCS_FLG_DPE] = busEvt.addrParityErr | busEvt.dataParityErr; // see (R17)
        stWrBits = '0;
        stWrBits[`PCS_FLG_MDPE] = cfgReq.wrData[`PCS_BIT_MDPE];
        stWrBits[`PCS_FLG_STA] = cfgReq.wrData[`PCS_BIT_STA];
        stWrBits[`PCS_FLG_RTA] = cfgReq.wrData[`PCS_BIT_RTA];
        stWrBits[`PCS_FLG_RMA] = cfgReq.wrData[`PCS_BIT_RMA];
        stWrBits[`PCS_FLG_SSE] = cfgReq.wrData[`PCS_BIT_SSE];
        stWrBits[`PCS_FLG_DPE] = cfgReq.wrData[`PCS_BIT_DPE];
        stClr = stWrBits & {`PCS_FLG_N{lane3Wr}}; // see (R21)
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PCS_FLG_N; gi = gi + 1)
        begin : g_flag
            pcs_w1c_flag u_flag
            (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .setEvt(stSet[gi]),
                .clrWr(stClr[gi]),
                .flag_r(stFlag[gi])
            );
        end
    endgenerate

    // Read words; hardwired and reserved bits built in
    always_comb
    begin
        cmdStatWord = `PCS_WORD_RST; // see (R21)
        cmdStatWord[`PCS_BIT_IOEN] = ioEn_r;
        cmdStatWord[`PCS_BIT_MEMEN] = memEn_r;
        cmdStatWord[`PCS_BIT_BMEN] = bmEn_r;
        cmdStatWord[`PCS_BIT_SPCYC] = `PCS_FIXED_ZERO; // see (R4)
        cmdStatWord[`PCS_BIT_MWI] = `PCS_FIXED_ZERO; // see (R5)
        cmdStatWord[`PCS_BIT_PERREN] = parityEn_r;
        cmdStatWord[`PCS_BIT_WAIT] = `PCS_FIXED_ZERO; // see (R7)
        cmdStatWord[`PCS_BIT_SERREN] = serrEn_r;
        cmdStatWord[`PCS_BIT_CAPLIST] = `PCS_CAP_PRESENT; // see (R10)
        cmdStatWord[`PCS_BIT_FBB:`PCS_BIT_M66] = `PCS_FEAT_NONE; // see (R11)
        cmdStatWord[`PCS_BIT_MDPE] = stFlag[`PCS_FLG_MDPE];
        cmdStatWord[`PCS_BIT_DEVSEL_HI:`PCS_BIT_DEVSEL_LO] = `PCS_DEVSEL_MEDIUM; // see (R13)
        cmdStatWord[`PCS_BIT_STA] = stFlag[`PCS_FLG_STA];
        cmdStatWord[`PCS_BIT_RTA] = stFlag[`PCS_FLG_RTA];
        cmdStatWord[`PCS_BIT_RMA] = stFlag[`PCS_FLG_RMA];
        cmdStatWord[`PCS_BIT_SSE] = stFlag[`PCS_FLG_SSE];
        cmdStatWord[`PCS_BIT_DPE] = stFlag[`PCS_FLG_DPE];
        revClassWord = {`PCS_CLASS_CODE, `PCS_REV_TOP, REV_ID}; // see (R18) see (R20)
    end

    // Read mux; unmapped offsets read zero, writes to read-only word dropped
    always_comb
    begin
        cfgRdData_nxt = `PCS_WORD_RST;
        if (cmdRd)
        begin
            cfgRdData_nxt = cmdStatWord;
        end
        else if (revRd)
        begin
            cfgRdData_nxt = revClassWord;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cfgRdData_r <= `PCS_WORD_RST;
            cfgRdValid_r <= `PCS_FLOP_RST;
        end
        else
        begin
            cfgRdData_r <= cfgRdData_nxt;
            cfgRdValid_r <= cfgReq.sel & ~cfgReq.wr;
        end
    end

    // Target claim gating
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            memClaim_r <= `PCS_FLOP_RST;
            ioClaim_r <= `PCS_FLOP_RST;
        end
        else
        begin
            // Card memory space bypasses the enable
            memClaim_r <= (decode.memHit & memEn_r) | decode.cardMemHit; // see (R1) see (R2)
            ioClaim_r <= decode.ioHit & (ioEn_r | otherIoEn); // see (R19)
        end
    end

    // Master request gating
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mstReqOut_r <= `PCS_FLOP_RST;
        end
        else
        begin
            mstReqOut_r <= decode.masterReq & bmEn_r; // see (R3)
        end
    end

    // Open-drain error pins: drive low while enabled
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            serrOe_r <= `PCS_FLOP_RST;
            serrOut_r <= `PCS_FLOP_RST;
            perrOe_r <= `PCS_FLOP_RST;
            perrOut_r <= `PCS_FLOP_RST;
        end
        else
        begin
            serrOe_r <= serrFire; // see (R8) see (R9)
            serrOut_r <= `PCS_PIN_LOW;
            perrOe_r <= perrFire; // see (R6)
            perrOut_r <= `PCS_PIN_LOW;
        end
    end

    // Checks
    sequence sAddrErrEnabled;
        busEvt.addrParityErr & serrEn_r & parityEn_r;
    endsequence

    sequence sSerrRaised;
        serrOe_r & stFlag[`PCS_FLG_SSE];
    endsequence

    sequence sReadCmd;
        cmdRd ##1 cfgRdValid_r;
    endsequence

    chk_mem_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R1)
        (decode.memHit & ~decode.cardMemHit & ~memEn_r) |=> !memClaim_r)
        else $error("memory claim while memory space disabled");

    chk_mem_claim: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R1)
        (decode.memHit & memEn_r) |=> memClaim_r)
        else $error("enabled memory hit not claimed");

    chk_card_space: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R2)
        decode.cardMemHit |=> memClaim_r)
        else $error("card memory access gated by enable");

    chk_io_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R19)
        ioClaim_r |-> $past(decode.ioHit & (ioEn_r | otherIoEn)))
        else $error("io claim without enable");

    chk_master_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R3)
        mstReqOut_r |-> $past(bmEn_r & decode.masterReq))
        else $error("master request while master disabled");

    chk_serr_report: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R9)
        sAddrErrEnabled |=> sSerrRaised)
        else $error("address parity error not reported");

    chk_serr_cause: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R8)
        serrOe_r |-> $past(busEvt.addrParityErr & serrEn_r & parityEn_r))
        else $error("system error without enabled address parity");

    chk_perr_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R6)
        (busEvt.dataParityErr & ~parityEn_r) |=> !perrOe_r)
        else $error("parity reported while checking disabled");

    chk_mdpe_cause: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R12)
        $rose(stFlag[`PCS_FLG_MDPE]) |->
            $past(busEvt.dataParityErr & busEvt.actingMaster & parityEn_r))
        else $error("master parity flag set without cause");

    chk_dpe_set: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R17)
        (busEvt.addrParityErr | busEvt.dataParityErr) |=> stFlag[`PCS_FLG_DPE])
        else $error("parity detected flag missed");

    chk_sta_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R14)
        (lane3Wr & cfgReq.wrData[`PCS_BIT_STA] & ~busEvt.targetAbortSent)
            |=> !stFlag[`PCS_FLG_STA])
        else $error("target abort flag not cleared by one");

    chk_rta_set: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R15)
        busEvt.targetAbortRcvd |=> stFlag[`PCS_FLG_RTA])
        else $error("received target abort not flagged");

    chk_rma_set: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R16)
        busEvt.masterAbortRcvd |=> stFlag[`PCS_FLG_RMA] [*2] or
            (stFlag[`PCS_FLG_RMA] ##1 $past(lane3Wr & cfgReq.wrData[`PCS_BIT_RMA])))
        else $error("master abort flag lost");

    chk_w1c_keep: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R21)
        (cmdWr & ~cfgReq.wrData[`PCS_BIT_RTA] & stFlag[`PCS_FLG_RTA])
            |=> stFlag[`PCS_FLG_RTA])
        else $error("writing zero cleared a flag");

    chk_fixed_bits: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R13)
        sReadCmd |-> (cfgRdData_r[`PCS_BIT_DEVSEL_HI:`PCS_BIT_DEVSEL_LO] == `PCS_DEVSEL_MEDIUM)
            && cfgRdData_r[`PCS_BIT_CAPLIST]
            && (cfgRdData_r[`PCS_BIT_FBB:`PCS_BIT_M66] == `PCS_FEAT_NONE)
            && !cfgRdData_r[`PCS_BIT_SPCYC] && !cfgRdData_r[`PCS_BIT_MWI]
            && !cfgRdData_r[`PCS_BIT_WAIT])
        else $error("hardwired command or status bit wrong");

    chk_class_code: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R20)
        revRd |=> (cfgRdData_r[`PCS_CLASS_MSB:`PCS_CLASS_LSB] == `PCS_CLASS_CODE)
            && (cfgRdData_r[`PCS_REV_TOP_MSB:`PCS_REV_TOP_LSB] == `PCS_REV_TOP))
        else $error("revision or class word wrong");

    chk_sta_set: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R14)
        busEvt.targetAbortSent |=> stFlag[`PCS_FLG_STA])
        else $error("signalled target abort not flagged");

    chk_mdpe_set: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R12)
        (busEvt.dataParityErr & busEvt.actingMaster & parityEn_r) |=> stFlag[`PCS_FLG_MDPE])
        else $error("master data parity error not flagged");

    chk_sse_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R9)
        (lane3Wr & cfgReq.wrData[`PCS_BIT_SSE] & ~serrFire) |=> !stFlag[`PCS_FLG_SSE])
        else $error("system error flag not cleared by one");

    chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R21)
        (cfgReq.sel & ~cfgReq.wr & ~cmdRd & ~revRd) |=> (cfgRdData_r == `PCS_WORD_RST))
        else $error("unmapped offset read not zero");

    chk_mem_en_write: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R1)
        lane0Wr |=> (memEn_r == $past(cfgReq.wrData[`PCS_BIT_MEMEN])))
        else $error("memory enable write lost");

    chk_serr_en_write: assert property (@(posedge clk_sys) disable iff (!rstn) // see (R8)
        lane1Wr |=> (serrEn_r == $past(cfgReq.wrData[`PCS_BIT_SERREN])))
        else $error("system error enable write lost");

endmodule : pcs_cfg_cmd_status

// ### rtl/pcs_params.svh
// Constants for the per-socket configuration command/status bank.
// Assumes inclusion by bare name from the package and the design modules.
// Function
// (R1) Memory enable gates memory cycle response
// (R2) Memory enable ignores sixteen-bit card space
// (R3) Master requests only while master enable
// (R4) Special cycle bit reads zero, never claimed
// (R5) Write-and-invalidate bit always reads zero
// (R6) Parity enable gates parity logic except bit31
// (R7) Stepping bit reads zero, never steps
// (R8) SERR enable allows SERR on address parity
// (R9) SERR needs bits 8,6; sets bit30
// (R10) Capability-list bit reads one
// (R11) Bits 23:21 read zero
// (R12) Master data parity flag, write-one clear
// (R13) DEVSEL timing field reads binary 01
// (R14) Signalled target abort flag, write-one clear
// (R15) Received target abort flag, write-one clear
// (R16) Received master abort flag, write-one clear
// (R17) Any parity error sets bit31 always
// (R18) Revision bits 7:6 one, rest fixed
// (R19) I/O enable, either socket, gates I/O
// (R20) Class code reads 060700h
// (R21) Reserved read zero; writing zero keeps flags
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

`define PCS_OFF_CMDSTAT 8'h04
`define PCS_OFF_REVCLASS 8'h08

`define PCS_BIT_IOEN 0
`define PCS_BIT_MEMEN 1
`define PCS_BIT_BMEN 2
`define PCS_BIT_SPCYC 3
`define PCS_BIT_MWI 4
`define PCS_BIT_PERREN 6
`define PCS_BIT_WAIT 7
`define PCS_BIT_SERREN 8
`define PCS_BIT_CAPLIST 20
`define PCS_BIT_FBB 23
`define PCS_BIT_M66 21
`define PCS_BIT_MDPE 24
`define PCS_BIT_DEVSEL_LO 25
`define PCS_BIT_DEVSEL_HI 26
`define PCS_BIT_STA 27
`define PCS_BIT_RTA 28
`define PCS_BIT_RMA 29
`define PCS_BIT_SSE 30
`define PCS_BIT_DPE 31

`define PCS_LANE_CMDLO 0
`define PCS_LANE_CMDHI 1
`define PCS_LANE_STHI 3

`define PCS_FLG_MDPE 0
`define PCS_FLG_STA 1
`define PCS_FLG_RTA 2
`define PCS_FLG_RMA 3
`define PCS_FLG_SSE 4
`define PCS_FLG_DPE 5
`define PCS_FLG_N 6

`define PCS_DEVSEL_MEDIUM 2'h1
`define PCS_CAP_PRESENT 1'h1
`define PCS_CLASS_CODE 24'h060700
`define PCS_CLASS_LSB 8
`define PCS_REV_TOP 2'h3
// Revision value is arbitrary
`define PCS_REV_ID_DEFAULT 6'h05
`define PCS_EN_RST 1'h0
`define PCS_WORD_RST 32'h0000_0000
`define PCS_FLOP_RST 1'h0
`define PCS_PIN_LOW 1'h0
`define PCS_FIXED_ZERO 1'h0
`define PCS_FEAT_NONE 3'h0
`define PCS_CLASS_MSB 31
`define PCS_REV_TOP_MSB 7
`define PCS_REV_TOP_LSB 6

`endif

// ### rtl/pcs_pkg.sv
// Types for the configuration command/status bank.
// Assumes the constant header sits beside it.
`include "pcs_params.svh"

package pcs_pkg;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wrData;
    } pcs_cfg_req_t;

    typedef struct packed {
        logic addrParityErr;
        logic dataParityErr;
        logic actingMaster;
        logic targetAbortSent;
        logic targetAbortRcvd;
        logic masterAbortRcvd;
    } pcs_evt_t;

    typedef struct packed {
        logic memHit;
        logic cardMemHit;
        logic ioHit;
        logic masterReq;
    } pcs_dec_t;

endpackage : pcs_pkg

// ### rtl/pcs_w1c_flag.sv
// One sticky status flag, set by hardware, cleared by writing one.
// Assumes set and clear come from logic on clk_sys.
`timescale 1ns/100ps
`include "pcs_params.svh"

module pcs_w1c_flag
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic setEvt,
    input wire logic clrWr,
    output logic flag_r
);

    logic flag_nxt;

    // Set beats a clear in the same cycle
    always_comb
    begin
        flag_nxt = setEvt | (flag_r & ~clrWr);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            flag_r <= `PCS_FLOP_RST;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

endmodule : pcs_w1c_flag
